// [verilog/typec_ctl_pkg.sv]
package typec_ctl_pkg;

	// Register addresses
	localparam logic [7:0] ADDR_PORT_CONTROL           = 8'h04;
	localparam logic [7:0] ADDR_PORT_CONTROL_SECONDARY = 8'h05;
	localparam logic [7:0] ADDR_MANUAL_STATE_COMMAND   = 8'h09;

	// Reset values
	localparam logic [7:0] RST_PORT_CONTROL           = 8'h43;
	localparam logic [7:0] RST_PORT_CONTROL_SECONDARY = 8'h23;
	localparam logic [7:0] RST_MANUAL_STATE_COMMAND   = 8'h00;

	// Timing, in milliseconds and percent
	localparam int TOGGLE_BASE_MS      = 60;
	localparam int TOGGLE_STEP_MS      = 10;
	localparam int SINK_SHARE_BASE_PCT = 60;
	localparam int SINK_SHARE_STEP_PCT = 10;
	localparam int PCT_FULL            = 100;
	localparam int DEBOUNCE_BASE_MS    = 120;
	localparam int DEBOUNCE_STEP_MS    = 10;
	localparam logic [2:0] DEBOUNCE_MAX_CODE = 3'h6;

	// One millisecond at the 5 ns clock
	localparam int MS_NS             = 1000000;
	localparam int CLK_PERIOD_NS     = 5;
	localparam int MS_CYCLES_DEFAULT = MS_NS / CLK_PERIOD_NS;

	// Role code forced under the dead battery condition
	localparam logic [2:0] DEAD_BATTERY_ROLE = 3'h2;

	// Bit order of the synchronised pins
	localparam int PIN_EN    = 0;
	localparam int PIN_WEAK  = 1;
	localparam int PIN_DEAD  = 2;
	localparam int PIN_GPIO  = 3;
	localparam int PIN_COUNT = 4;
	localparam logic [PIN_COUNT-1:0] PIN_RESET = 4'h1;

	typedef struct packed {
		logic [1:0] toggle_cycle_period;
		logic [1:0] toggle_duty_split;
		logic       dangling_cable_aid_enable;
		logic [1:0] source_pullup_current;
		logic       global_int_mask;
	} port_control_t;

	typedef struct packed {
		logic       remedy_enable;
		logic [1:0] weak_supply_threshold;
		logic       weak_supply_sink_enable;
		logic       device_enable;
		logic [2:0] attach_debounce_time;
	} port_control_secondary_t;

	typedef struct packed {
		logic [1:0] unused;
		logic       force_source_cmd;
		logic       force_sink_cmd;
		logic       go_unattached_sink_cmd;
		logic       go_unattached_source_cmd;
		logic       disabled;
		logic       error_recovery_cmd;
	} manual_state_command_t;

	// One-cycle command pulses towards the port state machine
	typedef struct packed {
		logic error_recovery;
		logic force_source;
		logic force_sink;
		logic go_unattached_source;
		logic go_unattached_sink;
	} port_cmd_t;

	typedef enum logic [1:0] {
		PHASE_SINK   = 2'b01,
		PHASE_SOURCE = 2'b10
	} toggle_phase_t;

endpackage

// [verilog/pin_sync3.sv]
`timescale 1ns/1ps
module pin_sync3 import typec_ctl_pkg::*; #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             mclk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] synced
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} sync_state_t;

	sync_state_t s_q;
	sync_state_t s_d;

	// A bit changes only once the second and third stages agree
	always_comb begin
		s_d    = s_q;
		s_d.s1 = async_in;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.out[i] = s_q.s3[i];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
		end else begin
			s_q <= s_d;
		end
	end

	assign synced = s_q.out;
endmodule

// [verilog/ms_countdown.sv]
`timescale 1ns/1ps
module ms_countdown import typec_ctl_pkg::*; #(
	parameter int W = 8
) (
	input  wire logic         mclk,
	input  wire logic         rst_b,
	input  wire logic         clear,
	input  wire logic         start,
	input  wire logic         tick,
	input  wire logic [W-1:0] load_ms,
	output logic              done
);
	typedef struct packed {
		logic [W-1:0] left;
		logic         busy;
		logic         done;
	} cd_state_t;

	cd_state_t s_q;
	cd_state_t s_d;

	// Clear beats start so a dropped condition never fires late
	always_comb begin
		s_d      = s_q;
		s_d.done = 1'b0;
		if (clear) begin
			s_d.busy = 1'b0;
		end else if (start) begin
			s_d.left = load_ms;
			s_d.busy = (load_ms != '0);
		end else if (s_q.busy && tick) begin
			s_d.left = s_q.left - 1'b1;
			if (s_q.left == W'(1)) begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign done = s_q.done;
endmodule

// [verilog/typec_port_control_regs.sv]
// Notes on behaviour
// - Control 7:6 sets full toggle cycle: 60, 70, 80, 90 ms; resets 01.
// - Control 5:4 splits sink/source share 60/40 to 30/70; resets 00.
// - Control bit 3 enables dangling-cable attach aid; resets 0.
// - Control 2:1 picks pull-up 80/180/330 uA; 00 reserved; resets 01.
// - Control bit 0 is global interrupt mask; while 1 interrupt stays off; resets 1.
// - Secondary bit 7 enables remedy detection; resets 0.
// - Secondary 6:5 sets weak-supply threshold 3.0 to 3.3 V; resets 01.
// - Secondary bit 4 makes weak supply force sink role; resets 0.
// - Register mode: enabled only with secondary bit 3 set and enable pin low.
// - Secondary 2:0 sets debounce 120 to 180 ms in 10 ms; 111 reserved.
// - Manual bit 5 write-one forces source; self-clearing.
// - Manual bit 4 write-one forces sink; self-clearing.
// - Manual bit 3 write-one enters unattached sink; self-clearing.
// - Manual bit 2 write-one enters unattached source; self-clearing.
// - Manual bit 1 holds disabled state until software clears it.
// - Manual bit 0 write-one enters error recovery; self-clearing.
// - Several manual bits: only one acts, bit 0 first, then 5, 4, 2, 3; others cleared.
// - New port role waits for disabled clear, otherwise overrides manual commands.
// - Dead battery forces role code 010 regardless of role pin.
`timescale 1ns/1ps
module typec_port_control_regs import typec_ctl_pkg::*; #(
	parameter int MS_CYCLES = MS_CYCLES_DEFAULT
) (
	input  wire logic                    mclk,
	input  wire logic                    rst_b,
	input  wire logic [7:0]              reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_wr,
	output logic      [7:0]              reg_rdata,
	input  wire logic                    enable_pin_b,
	input  wire logic                    weak_supply_low,
	input  wire logic                    dead_battery,
	input  wire logic                    gpio_mode,
	input  wire logic                    irq_pending,
	input  wire logic                    portrole_written,
	input  wire logic [2:0]              portrole_code,
	input  wire logic                    attach_raw,
	output logic                         int_b,
	output logic                         device_enabled,
	output logic                         port_disabled,
	output port_cmd_t                    port_cmd,
	output logic                         role_apply,
	output logic [2:0]                   effective_role,
	output port_control_t                ctl_fields,
	output port_control_secondary_t      sec_fields,
	output logic                         weak_supply_sink_active,
	output toggle_phase_t                toggle_phase,
	output logic                         attach_confirmed
);
	localparam int PRE_W = $clog2(MS_CYCLES + 1);

	typedef struct packed {
		port_control_t           ctl;
		port_control_secondary_t sec;
		logic                    disabled;
		logic                    role_pending;
		logic                    role_apply;
		port_cmd_t               cmd;
		logic [7:0]              rdata;
		logic                    int_b;
		logic                    enabled;
		logic                    run;
		logic                    auto_sink;
		logic [2:0]              eff_role;
		toggle_phase_t           phase;
		logic                    attach_q;
		logic                    attached;
		logic [PRE_W-1:0]        prescale;
		logic                    tick;
	} regs_state_t;

	regs_state_t             s_q;
	regs_state_t             s_d;
	logic [PIN_COUNT-1:0]    pins;
	logic                    toggle_done;
	logic                    toggle_start;
	logic [7:0]              toggle_load;
	logic                    deb_done;
	logic                    deb_start;
	logic [7:0]              deb_load;
	logic                    wr_manual;
	manual_state_command_t   man_w;

	function automatic logic [7:0] sink_ms(input logic [1:0] period, input logic [1:0] split);
		logic [12:0] per;
		logic [12:0] pct;
		logic [12:0] prod;
		per  = 13'(TOGGLE_BASE_MS + TOGGLE_STEP_MS * int'(period));
		pct  = 13'(SINK_SHARE_BASE_PCT - SINK_SHARE_STEP_PCT * int'(split));
		prod = per * pct;
		return 8'(prod / 13'(PCT_FULL));
	endfunction

	function automatic logic [7:0] cycle_ms(input logic [1:0] period);
		return 8'(TOGGLE_BASE_MS + TOGGLE_STEP_MS * int'(period));
	endfunction

	pin_sync3 #(
		.WIDTH     (PIN_COUNT),
		.RESET_VAL (PIN_RESET)
	) u_pins (
		.mclk     (mclk),
		.rst_b    (rst_b),
		.async_in ({gpio_mode, dead_battery, weak_supply_low, enable_pin_b}),
		.synced   (pins)
	);

	ms_countdown #(.W(8)) u_toggle (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.clear   (!s_q.run),
		.start   (toggle_start),
		.tick    (s_q.tick),
		.load_ms (toggle_load),
		.done    (toggle_done)
	);

	ms_countdown #(.W(8)) u_debounce (
		.mclk    (mclk),
		.rst_b   (rst_b),
		.clear   (!attach_raw),
		.start   (deb_start),
		.tick    (s_q.tick),
		.load_ms (deb_load),
		.done    (deb_done)
	);

	assign wr_manual = reg_wr && (reg_addr == ADDR_MANUAL_STATE_COMMAND);
	assign man_w     = manual_state_command_t'(reg_wdata);

	// Debounce length, reserved code held at the longest
	assign deb_load  = 8'(DEBOUNCE_BASE_MS + DEBOUNCE_STEP_MS *
		int'((s_q.sec.attach_debounce_time > DEBOUNCE_MAX_CODE) ? DEBOUNCE_MAX_CODE
		: s_q.sec.attach_debounce_time));
	assign deb_start = attach_raw && !s_q.attach_q;

	always_comb begin
		s_d          = s_q;
		toggle_start = 1'b0;
		toggle_load  = 8'h00;

		// Millisecond prescaler shared by both timers
		s_d.tick = 1'b0;
		if (s_q.prescale == PRE_W'(MS_CYCLES - 1)) begin
			s_d.prescale = '0;
			s_d.tick     = 1'b1;
		end else begin
			s_d.prescale = s_q.prescale + 1'b1;
		end

		// Plain read/write of both control registers
		if (reg_wr && reg_addr == ADDR_PORT_CONTROL) begin
			s_d.ctl = port_control_t'(reg_wdata);
		end
		if (reg_wr && reg_addr == ADDR_PORT_CONTROL_SECONDARY) begin
			s_d.sec = port_control_secondary_t'(reg_wdata);
		end

		// Disabled bit is an ordinary stored bit
		if (wr_manual) begin
			s_d.disabled = man_w.disabled;
		end

		// Role change held back while disabled, then overrides commands
		s_d.role_apply   = (portrole_written || s_q.role_pending) && !s_d.disabled;
		s_d.role_pending = (portrole_written || s_q.role_pending) && s_d.disabled;

		// Only the first written command in the order bit 0, 5, 4, 2, 3 acts, rest are dropped
		s_d.cmd = '0;
		if (wr_manual && !s_d.disabled && !s_d.role_apply) begin
			if (man_w.error_recovery_cmd) begin
				s_d.cmd.error_recovery = 1'b1;
			end else if (man_w.force_source_cmd) begin
				s_d.cmd.force_source = 1'b1;
			end else if (man_w.force_sink_cmd) begin
				s_d.cmd.force_sink = 1'b1;
			end else if (man_w.go_unattached_source_cmd) begin
				s_d.cmd.go_unattached_source = 1'b1;
			end else if (man_w.go_unattached_sink_cmd) begin
				s_d.cmd.go_unattached_sink = 1'b1;
			end
		end

		// Global mask keeps the interrupt line released
		s_d.int_b = !(irq_pending && !s_q.ctl.global_int_mask);

		// Register mode needs both the bit and the pin
		if (pins[PIN_GPIO]) begin
			s_d.enabled = !pins[PIN_EN];
		end else begin
			s_d.enabled = s_q.sec.device_enable && !pins[PIN_EN];
		end

		// Weak supply drops the port to sink
		s_d.auto_sink = s_q.sec.weak_supply_sink_enable && pins[PIN_WEAK];

		// Dead battery pins the role to sink only
		s_d.eff_role = pins[PIN_DEAD] ? DEAD_BATTERY_ROLE : portrole_code;

		// Toggle between sink and source shares while the port is enabled and not disabled
		s_d.run = s_q.enabled && !s_q.disabled;
		// Stopping parks the phase so a restart always begins in the sink share
		if (s_q.run && !s_d.run) begin
			s_d.phase = PHASE_SINK;
		end
		if (s_d.run && !s_q.run) begin
			s_d.phase    = PHASE_SINK;
			toggle_start = 1'b1;
		end else if (s_q.cmd.go_unattached_source) begin
			// Restart the cycle in the source share
			s_d.phase    = PHASE_SOURCE;
			toggle_start = 1'b1;
		end else if (s_q.cmd.go_unattached_sink) begin
			// Restart the cycle in the sink share
			s_d.phase    = PHASE_SINK;
			toggle_start = 1'b1;
		end else if (toggle_done) begin
			s_d.phase    = (s_q.phase == PHASE_SINK) ? PHASE_SOURCE : PHASE_SINK;
			toggle_start = 1'b1;
		end
		unique case (s_d.phase)
			PHASE_SINK: begin
				toggle_load = sink_ms(s_q.ctl.toggle_cycle_period, s_q.ctl.toggle_duty_split);
			end
			PHASE_SOURCE: begin
				toggle_load = cycle_ms(s_q.ctl.toggle_cycle_period)
					- sink_ms(s_q.ctl.toggle_cycle_period, s_q.ctl.toggle_duty_split);
			end
			default: begin
				toggle_load = 8'h00;
			end
		endcase

		// Attach confirmed only after a full quiet debounce
		s_d.attach_q = attach_raw;
		if (!attach_raw) begin
			s_d.attached = 1'b0;
		end else if (deb_done) begin
			s_d.attached = 1'b1;
		end

		// Self-clearing bits always read back as zero
		unique case (reg_addr)
			ADDR_PORT_CONTROL:           s_d.rdata = s_d.ctl;
			ADDR_PORT_CONTROL_SECONDARY: s_d.rdata = s_d.sec;
			ADDR_MANUAL_STATE_COMMAND:   s_d.rdata = {6'h00, s_d.disabled, 1'b0};
			default:                     s_d.rdata = 8'h00;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_q          <= '0;
			s_q.ctl      <= port_control_t'(RST_PORT_CONTROL);
			s_q.sec      <= port_control_secondary_t'(RST_PORT_CONTROL_SECONDARY);
			s_q.disabled <= RST_MANUAL_STATE_COMMAND[1];
			s_q.int_b    <= 1'b1;
			s_q.phase    <= PHASE_SINK;
		end else begin
			s_q <= s_d;
		end
	end

	assign reg_rdata               = s_q.rdata;
	assign int_b                   = s_q.int_b;
	assign device_enabled          = s_q.enabled;
	assign port_disabled           = s_q.disabled;
	assign port_cmd                = s_q.cmd;
	assign role_apply              = s_q.role_apply;
	assign effective_role          = s_q.eff_role;
	// Aid enables go straight out to the detection logic
	// Pull-up code passed as stored, reserved code included
	// Remedy enable passed to the detection logic
	// Threshold code drives the supply comparator
	assign ctl_fields              = s_q.ctl;
	assign sec_fields              = s_q.sec;
	assign weak_supply_sink_active = s_q.auto_sink;
	assign toggle_phase            = s_q.phase;
	assign attach_confirmed        = s_q.attached;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);

	sequence man_write_s(logic [7:0] v);
		wr_manual && reg_wdata == v && !portrole_written && !s_q.role_pending;
	endsequence

	mask_holds_int_a: assert property (s_q.ctl.global_int_mask [*2] |-> int_b)
		else $error("interrupt asserted while globally masked");
	enable_gate_a: assert property ((!pins[PIN_GPIO] && !s_q.sec.device_enable) |=> !device_enabled)
		else $error("enabled without enable bit");
	force_source_cmd_a: assert property (man_write_s(8'h20) |=> port_cmd.force_source ##1 !port_cmd.force_source)
		else $error("force source not a single pulse");
	force_sink_cmd_a: assert property (man_write_s(8'h10) |=> port_cmd.force_sink && !port_cmd.force_source)
		else $error("force sink missing");
	go_unattached_source_cmd_a: assert property (man_write_s(8'h04) |=> ##2 toggle_phase == PHASE_SOURCE || !s_q.run)
		else $error("unattached source not entered");
	err_rec_a: assert property (man_write_s(8'h3d) |=> port_cmd == 5'h10)
		else $error("error recovery lost priority");
	one_cmd_a: assert property (port_cmd != '0 |-> $onehot(port_cmd) && !port_disabled)
		else $error("several commands or command while disabled");
	role_wait_a: assert property (role_apply |-> !port_disabled)
		else $error("role applied while disabled");
	dead_role_a: assert property (pins[PIN_DEAD] |=> effective_role == 3'h2)
		else $error("dead battery role not sink only");
	man_read_a: assert property (reg_addr == ADDR_MANUAL_STATE_COMMAND |=> reg_rdata[7:2] == 6'h00 && !reg_rdata[0])
		else $error("self-clearing bit read back set");
endmodule

// [dv/port_partner.sv]
`timescale 1ns/1ps
module port_partner import typec_ctl_pkg::*; (
	input  wire logic      mclk,
	input  wire logic      rst_b,
	input  wire port_cmd_t port_cmd,
	input  wire logic      port_disabled,
	output logic           attach_raw
);
	// Far-side source: attaches only once we are forced to sink
	// attach follows commands
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			attach_raw <= 1'b0;
		end else if (port_disabled || port_cmd.error_recovery) begin
			attach_raw <= 1'b0;
		end else if (port_cmd.force_sink) begin
			attach_raw <= 1'b1;
		end
	end
endmodule

// [dv/typec_port_control_regs_tb.sv]
`timescale 1ns/1ps
module typec_port_control_regs_tb import typec_ctl_pkg::*;;
	logic                    mclk, rst_b, reg_wr, enable_pin_b, weak_supply_low, dead_battery;
	logic                    gpio_mode, irq_pending, portrole_written, attach_raw, int_b;
	logic                    device_enabled, port_disabled, role_apply, weak_supply_sink_active;
	logic                    attach_confirmed;
	logic [7:0]              reg_addr, reg_wdata, reg_rdata, v;
	logic [2:0]              portrole_code, effective_role;
	port_cmd_t               port_cmd;
	port_control_t           ctl_fields;
	port_control_secondary_t sec_fields;
	toggle_phase_t           toggle_phase;
	logic [4:0]              cmd_q[$];
	int                      error_cnt, checks, cyc, role_cnt;
	integer                  seed;
	logic [7:0]              cmd_data[9] = '{8'h01, 8'h20, 8'h10, 8'h04, 8'h08, 8'h3d, 8'h3c, 8'h1c, 8'h0c};
	logic [4:0]              cmd_exp[9]  = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h10, 5'h08, 5'h04, 5'h02};

	typec_port_control_regs #(.MS_CYCLES(10)) i_typec_port_control_regs (
		.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rdata(reg_rdata), .enable_pin_b(enable_pin_b), .weak_supply_low(weak_supply_low),
		.dead_battery(dead_battery), .gpio_mode(gpio_mode), .irq_pending(irq_pending),
		.portrole_written(portrole_written), .portrole_code(portrole_code), .attach_raw(attach_raw),
		.int_b(int_b), .device_enabled(device_enabled), .port_disabled(port_disabled),
		.port_cmd(port_cmd), .role_apply(role_apply), .effective_role(effective_role),
		.ctl_fields(ctl_fields), .sec_fields(sec_fields),
		.weak_supply_sink_active(weak_supply_sink_active), .toggle_phase(toggle_phase),
		.attach_confirmed(attach_confirmed));

	port_partner i_port_partner (
		.mclk(mclk), .rst_b(rst_b), .port_cmd(port_cmd), .port_disabled(port_disabled),
		.attach_raw(attach_raw));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("error_cnt=%0d checks=%0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge mclk);
		reg_addr = a;
		@(negedge mclk);
		chk(reg_rdata, exp);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask

	// Command pulses are matched against the oldest note
	always @(negedge mclk) begin
		if (rst_b && port_cmd !== 5'h00) begin
			if (cmd_q.size() == 0)
				chk({3'h0, port_cmd}, 8'h00);
			else
				chk({3'h0, port_cmd}, {3'h0, cmd_q.pop_front()});
		end
		if (role_apply === 1'b1)
			role_cnt++;
	end

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			wrap_up();
		end
	end

	initial begin
		seed = 32'hb0d1e4d4;
		{rst_b, reg_wr, weak_supply_low, dead_battery, gpio_mode, irq_pending, portrole_written} = '0;
		{reg_addr, reg_wdata, portrole_code} = '0;
		enable_pin_b = 1'b1;
		error_cnt = 0;
		checks = 0;
		cyc = 0;
		role_cnt = 0;
		repeat (10) @(negedge mclk);
		rst_b = 1'b1;
		rd(ADDR_PORT_CONTROL, 8'h43);
		rd(ADDR_PORT_CONTROL_SECONDARY, 8'h23);
		rd(ADDR_MANUAL_STATE_COMMAND, 8'h00);
		wr(8'h06, 8'hff);
		rd(8'h06, 8'h00);
		for (int i = 0; i < 6; i++) begin
			v = 8'($random(seed));
			wr(ADDR_PORT_CONTROL, v);
			rd(ADDR_PORT_CONTROL, v);
			chk(ctl_fields, v);
			// Debounce code 7 is reserved, so it is kept out of random writes
			if (v[2:0] == 3'h7)
				v[2:0] = 3'h6;
			wr(ADDR_PORT_CONTROL_SECONDARY, v);
			chk(sec_fields, v);
		end
		wr(ADDR_PORT_CONTROL, 8'h43);
		for (int i = 0; i < 9; i++) begin
			cmd_q.push_back(cmd_exp[i]);
			wr(ADDR_MANUAL_STATE_COMMAND, cmd_data[i]);
			rd(ADDR_MANUAL_STATE_COMMAND, 8'h00);
		end
		wr(ADDR_MANUAL_STATE_COMMAND, 8'h00);
		wr(ADDR_MANUAL_STATE_COMMAND, 8'h23);
		rd(ADDR_MANUAL_STATE_COMMAND, 8'h02);
		chk(port_disabled, 1'b1);
		portrole_code = 3'h1;
		portrole_written = 1'b1;
		@(negedge mclk);
		portrole_written = 1'b0;
		idle(3);
		chk(8'(role_cnt), 8'h00);
		wr(ADDR_MANUAL_STATE_COMMAND, 8'h00);
		idle(2);
		chk(8'(role_cnt), 8'h01);
		chk(port_disabled, 1'b0);
		reg_addr = ADDR_MANUAL_STATE_COMMAND;
		reg_wdata = 8'h20;
		reg_wr = 1'b1;
		portrole_written = 1'b1;
		@(negedge mclk);
		{reg_wr, portrole_written} = 2'b00;
		idle(3);
		chk(8'(role_cnt), 8'h02);
		portrole_code = 3'h4;
		idle(8);
		chk(effective_role, 3'h4);
		dead_battery = 1'b1;
		idle(8);
		chk(effective_role, 3'h2);
		dead_battery = 1'b0;
		irq_pending = 1'b1;
		idle(3);
		chk(int_b, 1'b1);
		wr(ADDR_PORT_CONTROL, 8'h42);
		idle(2);
		chk(int_b, 1'b0);
		wr(ADDR_PORT_CONTROL, 8'h43);
		idle(2);
		chk(int_b, 1'b1);
		wr(ADDR_PORT_CONTROL_SECONDARY, 8'h3b);
		enable_pin_b = 1'b0;
		weak_supply_low = 1'b1;
		idle(8);
		chk(device_enabled, 1'b1);
		chk(weak_supply_sink_active, 1'b1);
		enable_pin_b = 1'b1;
		weak_supply_low = 1'b0;
		idle(8);
		chk(device_enabled, 1'b0);
		chk(weak_supply_sink_active, 1'b0);
		enable_pin_b = 1'b0;
		wr(ADDR_PORT_CONTROL_SECONDARY, 8'h38);
		idle(8);
		// Source share of a 70 ms cycle at 60/40 is 28 ticks of 10 cycles
		cmd_q.push_back(5'h02);
		wr(ADDR_MANUAL_STATE_COMMAND, 8'h04);
		idle(2);
		chk(8'(toggle_phase), 8'(PHASE_SOURCE));
		idle(265);
		chk(8'(toggle_phase), 8'(PHASE_SOURCE));
		idle(20);
		chk(8'(toggle_phase), 8'(PHASE_SINK));
		cmd_q.push_back(5'h10);
		wr(ADDR_MANUAL_STATE_COMMAND, 8'h01);
		cmd_q.push_back(5'h04);
		wr(ADDR_MANUAL_STATE_COMMAND, 8'h10);
		idle(1100);
		chk(attach_confirmed, 1'b0);
		idle(200);
		chk(attach_confirmed, 1'b1);
		cmd_q.push_back(5'h10);
		wr(ADDR_MANUAL_STATE_COMMAND, 8'h01);
		idle(3);
		chk(attach_confirmed, 1'b0);
		chk(8'(cmd_q.size()), 8'h00);
		// Pin-configured mode ignores the enable bit
		wr(ADDR_PORT_CONTROL_SECONDARY, 8'h30);
		gpio_mode = 1'b1;
		idle(8);
		chk(device_enabled, 1'b1);
		gpio_mode = 1'b0;
		idle(8);
		chk(device_enabled, 1'b0);
		wrap_up();
	end
endmodule
